// *** verilog/fips_regs.svh ***
// register select codes, field positions and timing constants of the sequencer
`ifndef FIPS_REGS_SVH
`define FIPS_REGS_SVH
`define FIPS_SEL_CTRL_MAIN 4'h0
`define FIPS_SEL_CTRL_AUX 4'h1
`define FIPS_SEL_ADDR_LOW 4'h2
`define FIPS_SEL_ADDR_HIGH 4'h3
`define FIPS_SEL_DATA_LOW 4'h4
`define FIPS_SEL_DATA_HIGH 4'h5
`define FIPS_SEL_KEY_BASE 4'h6
`define FIPS_B_ENABLED 7
`define FIPS_B_OP_HI 6
`define FIPS_B_OP_LO 4
`define FIPS_B_TRIGGER 3
`define FIPS_B_PROG 2
`define FIPS_B_GATE 1
`define FIPS_B_READ 0
`define FIPS_B_TSEL 1
`define FIPS_B_BCLR 0
`define FIPS_OP_WRITE 3'h0
`define FIPS_OP_ERASE 3'h1
`define FIPS_OP_READ 3'h3
`define FIPS_OP_UNLOCK 3'h6
`define FIPS_KEY_PATTERN 48'h40_09_04_C3_0D_00
`define FIPS_PAGE_LAST 5'h1F
`define FIPS_CLK_NS 10
`define FIPS_ERASE0_NS 3200000
`define FIPS_WRITE0_NS 2200000
`define FIPS_ERASE1_NS 3700000
`define FIPS_WRITE1_NS 3000000
`define FIPS_UNLOCK_CYC 1024
`define FIPS_INSTR_CLKS 4
`define FIPS_READ_INSTR 3
`define FIPS_TMR_W 19
`endif

// *** verilog/fips_pkg.sv ***
// types shared by the flash programming sequencer
package fips_pkg;
	typedef enum logic [3:0] {
		FIPS_IDLE = 4'h1,
		FIPS_ERASE = 4'h2,
		FIPS_WRITE = 4'h4,
		FIPS_READ = 4'h8
	} fips_state_t;
	typedef struct packed {
		logic en;
		logic [3:0] sel;
		logic [7:0] data;
	} fips_wr_t;
	typedef struct packed {
		logic [12:0] addr;
		logic [15:0] data;
	} fips_word_t;
endpackage : fips_pkg

// *** verilog/fips_seq.sv ***
// flash in-application programming sequencer: unlock, page buffer, erase, write, read
// Notes on behaviour
// RULE1 - unlock only recognised with op select 110
// RULE2 - trigger bit starts window timer, stays high
// RULE3 - software writes six key bytes in window
// RULE4 - window expiry clears trigger regardless of keys
// RULE5 - matching keys set enabled status, else stays
// RULE6 - writing zero to enabled clears it immediately
// RULE7 - 32-word buffer, page from address bits 12..5
// RULE8 - high byte loads word, advances buffer index
// RULE9 - buffer index stops at last word of page
// RULE10 - op 001 plus start erases page
// RULE11 - op 000 plus start writes buffer page
// RULE12 - buffer clear empties whole write buffer
// RULE13 - start held for full time, then hardware-cleared
// RULE14 - cpu stalled during read, erase, write
// RULE15 - erase and write only when enabled
// RULE16 - erase acts only on the tagged words of the page
// RULE17 - write commits buffer as one page image
// RULE18 - rewrite same page allowed without erase
// RULE19 - non-adjacent words need separate address loads
// RULE20 - op 011, gate, start read fetches word
// RULE21 - read needs no unlock
// RULE22 - read start falls after three instruction cycles
// RULE23 - run system clock at maximum frequency
// RULE24 - time select picks erase and write durations
// RULE25 - erase tag write tags address, stops 11111b
// RULE26 - software cannot set enabled status
// RULE27 - start without enable is ignored, stays low
`timescale 1ns/1ps
`include "fips_regs.svh"
module fips_seq
	import fips_pkg::*;
#(
	parameter int ERASE0_CYC = `FIPS_ERASE0_NS / `FIPS_CLK_NS,
	parameter int WRITE0_CYC = `FIPS_WRITE0_NS / `FIPS_CLK_NS,
	parameter int ERASE1_CYC = `FIPS_ERASE1_NS / `FIPS_CLK_NS,
	parameter int WRITE1_CYC = `FIPS_WRITE1_NS / `FIPS_CLK_NS
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// software register writes
	input wire fips_wr_t sw_wr_i,
	// register readback
	output logic [7:0] ctrl_main_o,
	output logic [7:0] ctrl_aux_o,
	output logic [12:0] flash_addr_reg_o,
	output logic [15:0] word_data_o,
	output logic [4:0] buf_index_o,
	output logic cpu_stall_o,
	// flash array side
	output logic flash_erase_o,
	output logic [31:0] flash_erase_mask_o,
	output logic flash_prog_o,
	output fips_word_t flash_word_o,
	output logic flash_rd_o,
	output logic [12:0] flash_rd_addr_o,
	input wire logic [15:0] flash_rdata_i
);
	localparam logic [`FIPS_TMR_W-1:0] READ_CYC =
		`FIPS_TMR_W'(`FIPS_READ_INSTR * `FIPS_INSTR_CLKS);

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	fips_state_t st_r, st_nxt;
	logic en_r, en_nxt, trig_r, trig_nxt, prog_r, prog_nxt;
	logic gate_r, gate_nxt, rd_r, rd_nxt, tsel_r, tsel_nxt;
	logic bclr_r, bclr_nxt;
	logic [2:0] op_r, op_nxt;
	logic [12:0] addr_r, addr_nxt;
	logic [7:0] dlo_r, dlo_nxt, dhi_r, dhi_nxt;
	logic [7:0] key_r [6];
	logic [7:0] key_nxt [6];
	logic [15:0] buf_r [32];
	logic [15:0] buf_nxt [32];
	logic [31:0] tag_r, tag_nxt;
	logic [4:0] ptr_r, ptr_nxt, idx_r, idx_nxt;
	logic [`FIPS_TMR_W-1:0] tmr_r, tmr_nxt;
	logic [10:0] win_r, win_nxt;
	logic erp_r, erp_nxt, wrp_r, wrp_nxt, rdp_r, rdp_nxt;
	fips_word_t fw_r, fw_nxt;

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	// RULE24
	function automatic logic [`FIPS_TMR_W-1:0] op_time(input logic erase,
		input logic sel);
		if (erase)
			op_time = sel ? `FIPS_TMR_W'(ERASE1_CYC) : `FIPS_TMR_W'(ERASE0_CYC);
		else
			op_time = sel ? `FIPS_TMR_W'(WRITE1_CYC) : `FIPS_TMR_W'(WRITE0_CYC);
	endfunction : op_time

	function automatic logic [4:0] step_ptr(input logic [4:0] p);
		step_ptr = (p == `FIPS_PAGE_LAST) ? p : p + 5'h1;
	endfunction : step_ptr

	logic keys_ok;
	always_comb
	begin
		keys_ok = ({key_r[5], key_r[4], key_r[3], key_r[2], key_r[1],
			key_r[0]} == `FIPS_KEY_PATTERN); // RULE3
	end

	// -------------------------------------------------------------
	// next-state logic
	// -------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		en_nxt = en_r;
		trig_nxt = trig_r;
		prog_nxt = prog_r;
		gate_nxt = gate_r;
		rd_nxt = rd_r;
		tsel_nxt = tsel_r;
		bclr_nxt = 1'b0;
		op_nxt = op_r;
		addr_nxt = addr_r;
		dlo_nxt = dlo_r;
		dhi_nxt = dhi_r;
		key_nxt = key_r;
		buf_nxt = buf_r;
		tag_nxt = tag_r;
		ptr_nxt = ptr_r;
		idx_nxt = idx_r;
		tmr_nxt = tmr_r;
		win_nxt = win_r;
		erp_nxt = 1'b0;
		wrp_nxt = 1'b0;
		rdp_nxt = 1'b0;
		fw_nxt = fw_r;
		// clear runs one cycle after the request so the bit reads back set
		if (bclr_r)
		begin
			for (int i = 0; i < 32; i++)
				buf_nxt[i] = 16'h0000; // RULE12
			tag_nxt = 32'h0000_0000;
		end
		// writes are only seen while the cpu runs, i.e. in idle
		if (sw_wr_i.en && st_r == FIPS_IDLE)
		begin
			case (sw_wr_i.sel)
				`FIPS_SEL_CTRL_MAIN:
				begin
					op_nxt = sw_wr_i.data[`FIPS_B_OP_HI:`FIPS_B_OP_LO];
					gate_nxt = sw_wr_i.data[`FIPS_B_GATE];
					if (!sw_wr_i.data[`FIPS_B_ENABLED])
						en_nxt = 1'b0; // RULE6 RULE26
					if (sw_wr_i.data[`FIPS_B_TRIGGER] && !trig_r &&
						op_nxt == `FIPS_OP_UNLOCK)
					begin
						trig_nxt = 1'b1; // RULE1 RULE2
						win_nxt = 11'h000;
					end
					if (sw_wr_i.data[`FIPS_B_PROG] && en_r &&
						(op_nxt == `FIPS_OP_ERASE ||
						op_nxt == `FIPS_OP_WRITE)) // RULE15 RULE27
					begin
						prog_nxt = 1'b1;
						tmr_nxt = '0;
						idx_nxt = 5'h00;
						if (op_nxt == `FIPS_OP_ERASE)
						begin
							st_nxt = FIPS_ERASE; // RULE10
							erp_nxt = 1'b1;
						end
						else
							st_nxt = FIPS_WRITE; // RULE11 RULE18
					end
					else if (sw_wr_i.data[`FIPS_B_READ] && gate_r &&
						op_nxt == `FIPS_OP_READ) // RULE20 RULE21
					begin
						rd_nxt = 1'b1;
						tmr_nxt = '0;
						rdp_nxt = 1'b1;
						st_nxt = FIPS_READ;
					end
				end
				`FIPS_SEL_CTRL_AUX:
				begin
					tsel_nxt = sw_wr_i.data[`FIPS_B_TSEL];
					bclr_nxt = sw_wr_i.data[`FIPS_B_BCLR];
				end
				`FIPS_SEL_ADDR_LOW:
				begin
					addr_nxt[7:0] = sw_wr_i.data;
					ptr_nxt = sw_wr_i.data[4:0];
				end
				`FIPS_SEL_ADDR_HIGH:
					addr_nxt[12:8] = sw_wr_i.data[4:0];
				`FIPS_SEL_DATA_LOW:
					dlo_nxt = sw_wr_i.data;
				`FIPS_SEL_DATA_HIGH:
				begin
					dhi_nxt = sw_wr_i.data;
					if (op_r == `FIPS_OP_WRITE)
						buf_nxt[ptr_r] = {sw_wr_i.data, dlo_r}; // RULE8
					if (op_r == `FIPS_OP_WRITE || op_r == `FIPS_OP_ERASE)
					begin
						tag_nxt[ptr_r] = 1'b1; // RULE25
						ptr_nxt = step_ptr(ptr_r); // RULE9
					end
				end
				default:
					if (sw_wr_i.sel < `FIPS_SEL_KEY_BASE + 4'h6 &&
						sw_wr_i.sel >= `FIPS_SEL_KEY_BASE)
						key_nxt[3'(sw_wr_i.sel - `FIPS_SEL_KEY_BASE)] =
							sw_wr_i.data;
			endcase
		end
		// unlock window; a hardware set beats a same-cycle software clear
		if (trig_r)
		begin
			win_nxt = win_r + 11'h001;
			if (win_r == 11'(`FIPS_UNLOCK_CYC - 1))
			begin
				trig_nxt = 1'b0; // RULE4
				if (keys_ok && op_r == `FIPS_OP_UNLOCK)
					en_nxt = 1'b1; // RULE5
			end
		end
		case (st_r)
			FIPS_IDLE:
				;
			FIPS_ERASE:
			begin
				tmr_nxt = tmr_r + 1'b1;
				if (tmr_r == op_time(1'b1, tsel_r) - 1'b1)
				begin
					prog_nxt = 1'b0; // RULE13
					st_nxt = FIPS_IDLE;
				end
			end
			FIPS_WRITE:
			begin
				// stream tagged buffer words into the addressed page
				tmr_nxt = tmr_r + 1'b1;
				if (tmr_r <= `FIPS_TMR_W'(`FIPS_PAGE_LAST))
				begin
					wrp_nxt = tag_r[idx_r]; // RULE17
					fw_nxt.addr = {addr_r[12:5], idx_r}; // RULE7
					fw_nxt.data = buf_r[idx_r];
					idx_nxt = idx_r + 5'h01;
				end
				if (tmr_r == op_time(1'b0, tsel_r) - 1'b1)
				begin
					prog_nxt = 1'b0; // RULE13
					st_nxt = FIPS_IDLE;
				end
			end
			FIPS_READ:
			begin
				tmr_nxt = tmr_r + 1'b1;
				if (tmr_r == READ_CYC - 1'b1)
				begin
					{dhi_nxt, dlo_nxt} = flash_rdata_i; // RULE22
					rd_nxt = 1'b0;
					st_nxt = FIPS_IDLE;
				end
			end
			default:
				st_nxt = FIPS_IDLE;
		endcase
	end

	// -------------------------------------------------------------
	// registers
	// -------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r <= FIPS_IDLE;
			en_r <= 1'b0;
			trig_r <= 1'b0;
			prog_r <= 1'b0;
			gate_r <= 1'b0;
			rd_r <= 1'b0;
			tsel_r <= 1'b0;
			bclr_r <= 1'b0;
			op_r <= 3'h0;
			addr_r <= 13'h0000;
			dlo_r <= 8'h00;
			dhi_r <= 8'h00;
			for (int i = 0; i < 6; i++)
				key_r[i] <= 8'h00;
			for (int i = 0; i < 32; i++)
				buf_r[i] <= 16'h0000;
			tag_r <= 32'h0000_0000;
			ptr_r <= 5'h00;
			idx_r <= 5'h00;
			tmr_r <= '0;
			win_r <= 11'h000;
			erp_r <= 1'b0;
			wrp_r <= 1'b0;
			rdp_r <= 1'b0;
			fw_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			en_r <= en_nxt;
			trig_r <= trig_nxt;
			prog_r <= prog_nxt;
			gate_r <= gate_nxt;
			rd_r <= rd_nxt;
			tsel_r <= tsel_nxt;
			bclr_r <= bclr_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			dlo_r <= dlo_nxt;
			dhi_r <= dhi_nxt;
			key_r <= key_nxt;
			buf_r <= buf_nxt;
			tag_r <= tag_nxt;
			ptr_r <= ptr_nxt;
			idx_r <= idx_nxt;
			tmr_r <= tmr_nxt;
			win_r <= win_nxt;
			erp_r <= erp_nxt;
			wrp_r <= wrp_nxt;
			rdp_r <= rdp_nxt;
			fw_r <= fw_nxt;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign ctrl_main_o = {en_r, op_r, trig_r, prog_r, gate_r, rd_r};
	assign ctrl_aux_o = {6'h00, tsel_r, bclr_r};
	assign flash_addr_reg_o = addr_r;
	assign word_data_o = {dhi_r, dlo_r};
	assign buf_index_o = ptr_r;
	assign cpu_stall_o = (st_r != FIPS_IDLE); // RULE14
	assign flash_erase_o = erp_r; // RULE16
	assign flash_erase_mask_o = tag_r;
	assign flash_prog_o = wrp_r;
	assign flash_word_o = fw_r;
	assign flash_rd_o = rdp_r;
	assign flash_rd_addr_o = addr_r;

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	// helper: length of the current read-start pulse, counted so the
	// check does not need a long unrolled repetition
	logic [`FIPS_TMR_W-1:0] rdlen_r, rdlen_nxt;
	always_comb
	begin
		rdlen_nxt = rd_r ? rdlen_r + 1'b1 : '0;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdlen_r <= '0;
		else
			rdlen_r <= rdlen_nxt;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_trig_window: assert property ($rose(trig_r) |-> trig_r [*8]) // RULE2
		else $error("unlock trigger fell early");
	a_trig_expire: assert property (trig_r && win_r == 11'(`FIPS_UNLOCK_CYC - 1)
		|=> !trig_r) // RULE4
		else $error("unlock trigger not cleared at expiry");
	a_enable_set: assert property ($rose(en_r) |-> $past(trig_r) && $past(keys_ok)
		&& $past(op_r) == `FIPS_OP_UNLOCK) // RULE5 RULE26
		else $error("enabled set without valid unlock");
	a_enable_clear: assert property (sw_wr_i.en && st_r == FIPS_IDLE &&
		sw_wr_i.sel == `FIPS_SEL_CTRL_MAIN && !sw_wr_i.data[`FIPS_B_ENABLED] &&
		!(trig_r && win_r == 11'(`FIPS_UNLOCK_CYC - 1)) |=> !en_r) // RULE6
		else $error("enabled not cleared by software");
	a_ptr_stop: assert property (ptr_r == `FIPS_PAGE_LAST && sw_wr_i.en &&
		sw_wr_i.sel == `FIPS_SEL_DATA_HIGH |=> ptr_r == `FIPS_PAGE_LAST) // RULE9
		else $error("buffer index wrapped");
	a_prog_guard: assert property ($rose(prog_r) |-> $past(en_r)) // RULE15 RULE27
		else $error("program start without enable");
	a_stall_busy: assert property (prog_r || rd_r |-> cpu_stall_o) // RULE14
		else $error("cpu not stalled during operation");
	a_read_time: assert property ($fell(rd_r) |-> rdlen_r == READ_CYC) // RULE22
		else $error("read start wrong length");
	a_erase_pulse: assert property ($rose(st_r == FIPS_ERASE) |-> flash_erase_o
		##1 !flash_erase_o) // RULE10 RULE16
		else $error("erase pulse missing");
	a_write_page: assert property (flash_prog_o |->
		flash_word_o.addr[12:5] == addr_r[12:5]) // RULE7 RULE17
		else $error("write left the page");

	c_unlock: cover property ($rose(en_r));
	c_erase: cover property ($fell(prog_r) && op_r == `FIPS_OP_ERASE);
	c_write: cover property ($fell(prog_r) && op_r == `FIPS_OP_WRITE);
	c_read: cover property ($fell(rd_r));
endmodule : fips_seq

// *** verification/fips_flash_model.sv ***
// behavioural flash array that answers the programming sequencer
`timescale 1ns/1ps
module fips_flash_model
	import fips_pkg::*;
(
	// clock
	input wire logic clk_i,
	// sequencer side
	input wire logic erase_i,
	input wire logic [31:0] erase_mask_i,
	input wire logic [12:0] page_addr_i,
	input wire logic prog_i,
	input wire fips_word_t word_i,
	input wire logic rd_i,
	input wire logic [12:0] rd_addr_i,
	output logic [15:0] rdata_o
);
	logic [15:0] mem [0:8191];
	logic [15:0] last;
	logic [4:0] hold;
	initial
	begin
		for (int i = 0; i < 8192; i++)
			mem[i] = 16'hFFFF;
		hold = 5'h00;
		last = 16'h0000;
		rdata_o = 16'hFFFF;
	end
	// outside the hold span the data lines toggle, so a stale sample shows
	always @(posedge clk_i)
	begin
		if (erase_i)
			for (int i = 0; i < 32; i++)
				if (erase_mask_i[i])
					mem[{page_addr_i[12:5], i[4:0]}] = 16'h0000;
		if (prog_i)
			mem[word_i.addr] = word_i.data;
		if (rd_i)
		begin
			last = mem[rd_addr_i];
			hold = 5'h0E;
		end
		else if (hold != 5'h00)
			hold = hold - 5'h01;
		rdata_o <= (hold != 5'h00) ? last : ~rdata_o;
	end
endmodule : fips_flash_model

// *** verification/fips_seq_tb.sv ***
// self-checking bench for the flash programming sequencer
`timescale 1ns/1ps
`include "fips_regs.svh"
module fips_seq_tb
	import fips_pkg::*;
;
	localparam int E0 = 40;
	localparam int W0 = 50;
	localparam int E1 = 60;
	localparam int W1 = 70;
	logic clk_i = 1'b0;
	logic rst_i;
	fips_wr_t sw_wr;
	logic [7:0] ctrl_main_o, ctrl_aux_o;
	logic [12:0] addr_reg, rd_addr;
	logic [15:0] word_data_o, rdata;
	logic [4:0] buf_index_o;
	logic cpu_stall_o, erase, prog, rd;
	logic [31:0] mask;
	fips_word_t word;
	logic [7:0] keep;
	int miscompares, n_tests;
	always #5 clk_i = ~clk_i;
	fips_seq #(.ERASE0_CYC(E0), .WRITE0_CYC(W0), .ERASE1_CYC(E1),
		.WRITE1_CYC(W1)) dut (.clk_i(clk_i), .rst_i(rst_i), .sw_wr_i(sw_wr),
		.ctrl_main_o(ctrl_main_o), .ctrl_aux_o(ctrl_aux_o),
		.flash_addr_reg_o(addr_reg), .word_data_o(word_data_o),
		.buf_index_o(buf_index_o), .cpu_stall_o(cpu_stall_o),
		.flash_erase_o(erase), .flash_erase_mask_o(mask),
		.flash_prog_o(prog), .flash_word_o(word), .flash_rd_o(rd),
		.flash_rd_addr_o(rd_addr), .flash_rdata_i(rdata));
	fips_flash_model flash (.clk_i(clk_i), .erase_i(erase),
		.erase_mask_i(mask), .page_addr_i(addr_reg), .prog_i(prog),
		.word_i(word), .rd_i(rd), .rd_addr_i(rd_addr), .rdata_o(rdata));
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	// hardware timers are allowed one cycle of slack either way
	task automatic near(input string name, input int exp, input int got);
		check(name, 16'(exp), 16'((got >= exp - 1 && got <= exp + 1) ? exp : got));
	endtask : near
	task automatic wr(input logic [3:0] sel, input logic [7:0] data);
		@(posedge clk_i);
		sw_wr <= {1'b1, sel, data};
		@(posedge clk_i);
		sw_wr.en <= 1'b0;
		#1;
	endtask : wr
	task automatic run_len(input int b, input int lim, output int n);
		n = 0;
		while (ctrl_main_o[b] === 1'b1 && n < lim)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
	endtask : run_len
	task automatic set_addr(input logic [12:0] a);
		wr(`FIPS_SEL_ADDR_LOW, a[7:0]);
		wr(`FIPS_SEL_ADDR_HIGH, {3'h0, a[12:8]});
	endtask : set_addr
	task automatic rd_word(input logic [12:0] a, input logic [15:0] exp);
		int n;
		set_addr(a);
		wr(`FIPS_SEL_CTRL_MAIN, keep | 8'h32);
		wr(`FIPS_SEL_CTRL_MAIN, keep | 8'h33);
		check("read stall", 16'h0001, 16'(cpu_stall_o));
		run_len(`FIPS_B_READ, 100, n);
		near("read time", 12, n);
		check("read word", exp, word_data_o);
	endtask : rd_word
	task automatic unlock(input logic [47:0] key, input logic exp);
		int n;
		wr(`FIPS_SEL_CTRL_MAIN, 8'h68);
		check("trigger", 16'h0001, 16'(ctrl_main_o[3]));
		for (int i = 0; i < 6; i++)
			wr(`FIPS_SEL_KEY_BASE + 4'(i), key[8*i +: 8]);
		run_len(`FIPS_B_TRIGGER, 1200, n);
		near("window", 1012, n);
		check("enabled", 16'(exp), 16'(ctrl_main_o[7]));
	endtask : unlock
	task automatic prog_run(input logic [7:0] cmd, input int exp);
		int n;
		wr(`FIPS_SEL_CTRL_MAIN, cmd);
		check("prog stall", 16'h0001, 16'(cpu_stall_o));
		run_len(`FIPS_B_PROG, 1000, n);
		near("prog time", exp, n);
	endtask : prog_run
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		stop_test();
	end
	initial
	begin
		rst_i = 1'b1;
		sw_wr = '0;
		keep = 8'h00;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		check("main reset", 16'h0000, 16'(ctrl_main_o));
		wr(`FIPS_SEL_CTRL_MAIN, 8'h80);
		check("set enabled", 16'h0000, 16'(ctrl_main_o));
		wr(`FIPS_SEL_CTRL_MAIN, 8'h08);
		check("trigger op", 16'h0000, 16'(ctrl_main_o[3]));
		wr(`FIPS_SEL_CTRL_MAIN, 8'h04);
		check("locked start", 16'h0000, 16'(ctrl_main_o[2]));
		$display("test refusals done");
		unlock(48'h40_09_04_C3_0D_01, 1'b0);
		unlock(48'h40_09_04_C3_0D_00, 1'b1);
		keep = 8'h80;
		$display("test unlock done");
		set_addr(13'h0140);
		wr(`FIPS_SEL_CTRL_AUX, 8'h01);
		check("clear bit", 16'h0001, 16'(ctrl_aux_o));
		wr(`FIPS_SEL_CTRL_MAIN, 8'h90);
		repeat (33) wr(`FIPS_SEL_DATA_HIGH, 8'h00);
		check("tag stop", 16'h001F, 16'(buf_index_o));
		check("addr kept", 16'h0140, 16'(addr_reg));
		prog_run(8'h94, E0);
		rd_word(13'h0145, 16'h0000);
		rd_word(13'h015F, 16'h0000);
		$display("test erase done");
		wr(`FIPS_SEL_CTRL_AUX, 8'h03);
		wr(`FIPS_SEL_CTRL_MAIN, 8'h80);
		set_addr(13'h0142);
		wr(`FIPS_SEL_DATA_LOW, 8'h34);
		wr(`FIPS_SEL_DATA_HIGH, 8'h12);
		check("index 3", 16'h0003, 16'(buf_index_o));
		wr(`FIPS_SEL_DATA_LOW, 8'hCD);
		wr(`FIPS_SEL_DATA_HIGH, 8'hAB);
		wr(`FIPS_SEL_DATA_LOW, 8'hAA);
		wr(`FIPS_SEL_DATA_HIGH, 8'h55);
		check("index 5", 16'h0005, 16'(buf_index_o));
		check("addr same", 16'h0142, 16'(addr_reg));
		prog_run(8'h84, W1);
		rd_word(13'h0142, 16'h1234);
		rd_word(13'h0143, 16'hABCD);
		rd_word(13'h0144, 16'h55AA);
		rd_word(13'h0141, 16'h0000);
		$display("test write done");
		wr(`FIPS_SEL_CTRL_AUX, 8'h01);
		wr(`FIPS_SEL_CTRL_MAIN, 8'h80);
		set_addr(13'h0142);
		wr(`FIPS_SEL_DATA_LOW, 8'h0F);
		wr(`FIPS_SEL_DATA_HIGH, 8'h0F);
		prog_run(8'h84, W0);
		rd_word(13'h0142, 16'h0F0F);
		rd_word(13'h0143, 16'hABCD);
		wr(`FIPS_SEL_CTRL_AUX, 8'h01);
		wr(`FIPS_SEL_CTRL_MAIN, 8'h80);
		set_addr(13'h014A);
		wr(`FIPS_SEL_DATA_LOW, 8'h77);
		wr(`FIPS_SEL_DATA_HIGH, 8'h66);
		prog_run(8'h84, W0);
		rd_word(13'h014A, 16'h6677);
		rd_word(13'h0142, 16'h0F0F);
		$display("test rewrite done");
		keep = 8'h00;
		wr(`FIPS_SEL_CTRL_MAIN, 8'h00);
		check("disable", 16'h0000, 16'(ctrl_main_o[7]));
		rd_word(13'h0143, 16'hABCD);
		wr(`FIPS_SEL_CTRL_MAIN, 8'h14);
		check("erase locked", 16'h0000, 16'(ctrl_main_o[2]));
		check("no stall", 16'h0000, 16'(cpu_stall_o));
		$display("test disable done");
		stop_test();
	end
endmodule : fips_seq_tb
